// File: core/vac_defines.vh
// constants for the video converter control block
`ifndef VAC_DEFINES_VH
`define VAC_DEFINES_VH
`define VAC_CTRL_ADDR      8'h00
`define VAC_STAT_ADDR      8'h04
`define VAC_FMT_LSB        0
`define VAC_SRC_LSB        2
`define VAC_CTRL_RESET     4'h2
`define VAC_FMT_TWOS       2'h0
`define VAC_FMT_HIZ        2'h1
`define VAC_FMT_BIN        2'h2
`define VAC_CUR_ZERO       3'h0
`define VAC_CUR_SRC_2U5    3'h1
`define VAC_CUR_SNK_2U5    3'h2
`define VAC_CUR_SRC_130U   3'h3
`define VAC_CUR_SRC_50U    3'h4
`define VAC_CUR_SNK_50U    3'h5
`define VAC_CLAMP_MID      8'h40
`define VAC_FULL_SCALE     8'hFF
`define VAC_MODE_ONE       2'h1
`define VAC_MODE_TWO       2'h2
`define VAC_MODE_NONE      2'h0
`endif

// File: core/vac_top.v
// video converter control: gain/clamp steering, output format, source select
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vac_defines.vh"

module vac_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_r;
    reg [AW:0]      rd_r;
    wire            full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire            empty = (wr_r == rd_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_r[AW-1:0]];
    always @(posedge clk)
    begin
        if (in_valid && !full)
            mem[wr_r[AW-1:0]] <= in_data;
    end
    always @(posedge clk)
    begin
        if (rst)
        begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (in_valid && !full)
                wr_r <= wr_r + 1'b1;
            if (out_ready && !empty)
                rd_r <= rd_r + 1'b1;
        end
    end
endmodule // vac_fifo

module vac_top #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire        SYS_CLK,
    input  wire        RST,
    input  wire        HSEL,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [7:0]  HADDR,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    input  wire        GATE_A,
    input  wire        GATE_B,
    input  wire        SAMPLE_STROBE,
    input  wire [7:0]  CONV_CODE,
    input  wire        CONV_UNDER,
    input  wire        CONV_OVER,
    input  wire        SAMPLE_READY,
    output reg         SAMPLE_VALID,
    output reg  [7:0]  SAMPLE_BUS,
    output reg         SAMPLE_BUS_OE_N,
    output reg  [1:0]  VIDEO_SOURCE_SEL,
    output reg  [2:0]  GAIN_CORRECTION_CURRENT,
    output reg  [2:0]  CLAMP_CURRENT
);
    reg  [12:0] s1_r;
    reg  [12:0] s2_r;
    reg         strobe_d_r;
    reg  [3:0]  ctrl_r;
    reg  [9:0]  smp_r;
    reg         smp_ok_r;
    reg  [1:0]  mode_r;
    reg         a_seen_r;
    reg         gb_d_r;
    reg         wr_pend_r;
    reg  [7:0]  addr_r;
    reg  [9:0]  out_raw_r;
    wire        ga = s2_r[0];
    wire        gb = s2_r[1];
    wire        strobe_rise = s2_r[2] && !strobe_d_r;
    wire [1:0]  fmt = ctrl_r[`VAC_FMT_LSB+1:`VAC_FMT_LSB];
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [9:0]  fifo_out_data;
    wire        out_take = fmt != `VAC_FMT_HIZ && (!SAMPLE_VALID || SAMPLE_READY);
    wire        below0  = smp_r[9];
    wire        above0  = !smp_r[9] && (smp_r[8] || smp_r[7:0] != 8'h00);
    wire        above255 = smp_r[8];
    wire        below64 = smp_r[9] || (!smp_r[8] && smp_r[7:0] < `VAC_CLAMP_MID);
    wire        above64 = !smp_r[9] && (smp_r[8] || smp_r[7:0] > `VAC_CLAMP_MID);

    // saturate to the 8-bit code, then flip the msb for two's complement
    function [7:0] vac_code;
        input [9:0] raw;
        input [1:0] f;
        reg   [7:0] b;
        begin
            b = raw[9] ? 8'h00 : (raw[8] ? `VAC_FULL_SCALE : raw[7:0]);
            vac_code = (f == `VAC_FMT_TWOS) ? {~b[7], b[6:0]} : b;
        end
    endfunction

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // pins are async to SYS_CLK
    always @(posedge SYS_CLK)
    begin
        s1_r <= {CONV_OVER, CONV_UNDER, CONV_CODE, SAMPLE_STROBE, GATE_B, GATE_A};
        s2_r <= s1_r;
    end
    wire [12:0] s_cur = s2_r;

    // zero-wait slave; read data registered in the address phase
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            ctrl_r    <= `VAC_CTRL_RESET;
            HRDATA    <= 32'h0000_0000;
        end
        else
        begin
            if (wr_pend_r && addr_r == `VAC_CTRL_ADDR)
                ctrl_r <= HWDATA[3:0];
            if (HREADY)
            begin
                wr_pend_r <= HSEL && HTRANS[1] && HWRITE;
                addr_r    <= HADDR;
                if (HSEL && HTRANS[1] && !HWRITE)
                begin
                    case (HADDR)
                        `VAC_CTRL_ADDR: HRDATA <= {28'h0000000, ctrl_r};
                        `VAC_STAT_ADDR: HRDATA <= {12'h000, !fifo_out_valid,
                                            !fifo_in_ready, CLAMP_CURRENT,
                                            GAIN_CORRECTION_CURRENT, mode_r, smp_r};
                        default:        HRDATA <= 32'h0000_0000;
                    endcase
                end
                else
                    HRDATA <= 32'h0000_0000;
            end
            else
                wr_pend_r <= 1'b0;
        end
    end

    // sample register: underflow bit 9, overflow bit 8, code 7:0
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            strobe_d_r <= 1'b0;
            smp_r      <= 10'h000;
            smp_ok_r   <= 1'b0;
        end
        else
        begin
            strobe_d_r <= s_cur[2];
            smp_ok_r   <= 1'b0;
            // full fifo stalls capture; the converter cannot wait, so samples drop
            if (strobe_rise && fifo_in_ready)
            begin
                smp_r    <= {s_cur[11], s_cur[12], s_cur[10:3]};
                smp_ok_r <= 1'b1;
            end
        end
    end

    // mode tracking: both high is mode 1; A pulse followed by B pulse is mode 2
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            mode_r   <= `VAC_MODE_NONE;
            a_seen_r <= 1'b0;
            gb_d_r   <= 1'b0;
        end
        else
        begin
            gb_d_r <= gb;
            if (ga && gb)
            begin
                mode_r   <= `VAC_MODE_ONE;
                a_seen_r <= 1'b0;
            end
            else
            begin
                if (ga && !gb)
                    a_seen_r <= 1'b1;
                if (a_seen_r && gb && !gb_d_r && !ga)
                    mode_r <= `VAC_MODE_TWO;
            end
        end
    end

    // current steering from registered gates and sample
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            GAIN_CORRECTION_CURRENT <= `VAC_CUR_ZERO;
            CLAMP_CURRENT           <= `VAC_CUR_ZERO;
        end
        else
        begin
            GAIN_CORRECTION_CURRENT <= `VAC_CUR_ZERO;
            if (ga && gb)
                GAIN_CORRECTION_CURRENT <= above255 ? `VAC_CUR_SRC_130U
                                                    : `VAC_CUR_SNK_2U5;
            else if (mode_r == `VAC_MODE_TWO && ga && !gb)
            begin
                if (below0)
                    GAIN_CORRECTION_CURRENT <= `VAC_CUR_SRC_2U5;
                else if (above0)
                    GAIN_CORRECTION_CURRENT <= `VAC_CUR_SNK_2U5;
            end
            CLAMP_CURRENT <= `VAC_CUR_ZERO;
            if (ga && gb)
            begin
                if (below0)
                    CLAMP_CURRENT <= `VAC_CUR_SRC_130U;
                else if (above0)
                    CLAMP_CURRENT <= `VAC_CUR_SNK_2U5;
            end
            else if (mode_r == `VAC_MODE_TWO && !ga && gb)
            begin
                if (below64)
                    CLAMP_CURRENT <= `VAC_CUR_SRC_50U;
                else if (above64)
                    CLAMP_CURRENT <= `VAC_CUR_SNK_50U;
            end
        end
    end

    vac_fifo #(
        .WIDTH (10),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_data   (smp_r),
        .in_valid  (smp_ok_r),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (out_take)
    );

    // output stage; raw kept so a format change recodes the held word
    always @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            SAMPLE_VALID     <= 1'b0;
            out_raw_r        <= 10'h000;
            SAMPLE_BUS       <= 8'h00;
            SAMPLE_BUS_OE_N  <= 1'b1;
            VIDEO_SOURCE_SEL <= 2'h0;
        end
        else
        begin
            SAMPLE_BUS_OE_N <= (fmt == `VAC_FMT_HIZ);
            VIDEO_SOURCE_SEL <= ctrl_r[`VAC_SRC_LSB+1] ? 2'h2
                              : {1'b0, ctrl_r[`VAC_SRC_LSB]};
            if (out_take)
            begin
                SAMPLE_VALID <= fifo_out_valid;
                if (fifo_out_valid)
                begin
                    out_raw_r  <= fifo_out_data;
                    SAMPLE_BUS <= vac_code(fifo_out_data, fmt);
                end
            end
            else if (fmt == `VAC_FMT_HIZ)
                SAMPLE_VALID <= 1'b0;
            else
                SAMPLE_BUS <= vac_code(out_raw_r, fmt);
        end
    end
endmodule // vac_top
`default_nettype wire

// File: sim/vac_sva.sv
// checker: port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "vac_defines.vh"
module vac_sva (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       GATE_A,
    input wire logic       GATE_B,
    input wire logic       SAMPLE_READY,
    input wire logic       SAMPLE_VALID,
    input wire logic [7:0] SAMPLE_BUS,
    input wire logic       SAMPLE_BUS_OE_N,
    input wire logic [1:0] VIDEO_SOURCE_SEL,
    input wire logic [2:0] GAIN_CORRECTION_CURRENT,
    input wire logic [2:0] CLAMP_CURRENT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // gates pass two sync flops, so hold them five edges first
    sequence s_both; (GATE_A && GATE_B) [*5]; endsequence
    sequence s_m2c; (!GATE_A && GATE_B) [*5]; endsequence
    sequence s_blow; (!GATE_B) [*5]; endsequence
    sequence s_alow; (!GATE_A) [*5]; endsequence
    property p_clamp_off; s_blow |=> CLAMP_CURRENT == `VAC_CUR_ZERO; endproperty
    a_clamp_off: assert property (p_clamp_off) else $error("clamp on");
    property p_gain_off; s_alow |=> GAIN_CORRECTION_CURRENT == `VAC_CUR_ZERO; endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain on");
    property p_m1_gain; s_both |=> GAIN_CORRECTION_CURRENT inside
        {`VAC_CUR_SNK_2U5, `VAC_CUR_SRC_130U}; endproperty
    a_m1_gain: assert property (p_m1_gain) else $error("mode one gain");
    property p_m1_clamp; s_both |=> CLAMP_CURRENT inside
        {`VAC_CUR_ZERO, `VAC_CUR_SNK_2U5, `VAC_CUR_SRC_130U}; endproperty
    a_m1_clamp: assert property (p_m1_clamp) else $error("mode one clamp");
    property p_m2_clamp; s_m2c |=> CLAMP_CURRENT inside
        {`VAC_CUR_ZERO, `VAC_CUR_SRC_50U, `VAC_CUR_SNK_50U}; endproperty
    a_m2_clamp: assert property (p_m2_clamp) else $error("mode two clamp");
    property p_src; VIDEO_SOURCE_SEL != 2'h3; endproperty
    a_src: assert property (p_src) else $error("bad source");
    property p_hiz; SAMPLE_BUS_OE_N |-> !SAMPLE_VALID; endproperty
    a_hiz: assert property (p_hiz) else $error("valid while off bus");
    property p_hold; SAMPLE_VALID && !SAMPLE_READY |=> SAMPLE_VALID && $stable(SAMPLE_BUS);
    endproperty
    a_hold: assert property (p_hold) else $error("sample lost");
endmodule // vac_sva
bind vac_top vac_sva u_vac_sva (.SYS_CLK, .RST, .GATE_A, .GATE_B, .SAMPLE_READY,
    .SAMPLE_VALID, .SAMPLE_BUS, .SAMPLE_BUS_OE_N, .VIDEO_SOURCE_SEL,
    .GAIN_CORRECTION_CURRENT, .CLAMP_CURRENT);
`default_nettype wire

// File: sim/vac_sink.sv
// partner: downstream sample sink that can stall
`timescale 1ns/1ps
`default_nettype none
module vac_sink (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        valid,
    input  wire logic [7:0]  data,
    input  wire logic        stall,
    output var  logic        ready = 1'b0,
    output var  logic [7:0]  last,
    output var  logic [15:0] cnt
);
    // a word counts only where valid and ready meet at an edge
    always @(posedge clk)
    begin
        ready <= !rst && !stall;
        if (rst)
            cnt <= 16'h0;
        else if (valid && ready)
        begin
            last <= data;
            cnt  <= cnt + 16'h1;
        end
    end
endmodule // vac_sink
`default_nettype wire

// File: sim/test_vac.sv
// testbench: bus, format, source, current steering and buffering
`timescale 1ns/1ps
`default_nettype none
`include "vac_defines.vh"
module test_video_adc_clamp_gain_output_control;
    logic        clk = 0, rst = 1, hsel = 0, hwr = 0, ga = 0, gb = 0;
    logic        strb = 0, und = 0, ovr = 0, stall = 0, rdy, hro, hresp, vld, oe_n;
    logic [1:0]  htr = 0, src;
    logic [7:0]  ha = 0, code = 0, bus, last;
    logic [31:0] hwd = 0, hrd, rdat;
    logic [2:0]  gain, clamp;
    logic [15:0] cnt, n0;
    int          miscompares = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    vac_top u_vac_top (.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HTRANS(htr), .HWRITE(hwr),
        .HSIZE(3'h2), .HADDR(ha), .HWDATA(hwd), .HREADY(hro), .HRDATA(hrd),
        .HREADYOUT(hro), .HRESP(hresp), .GATE_A(ga), .GATE_B(gb), .SAMPLE_STROBE(strb),
        .CONV_CODE(code), .CONV_UNDER(und), .CONV_OVER(ovr), .SAMPLE_READY(rdy),
        .SAMPLE_VALID(vld), .SAMPLE_BUS(bus), .SAMPLE_BUS_OE_N(oe_n),
        .VIDEO_SOURCE_SEL(src), .GAIN_CORRECTION_CURRENT(gain), .CLAMP_CURRENT(clamp));
    vac_sink u_vac_sink (.clk(clk), .rst(rst), .valid(vld), .data(bus), .stall(stall),
        .ready(rdy), .last(last), .cnt(cnt));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htr <= 2'h2;
        hwr <= w;
        ha <= a;
        do @(posedge clk); while (hro !== 1'b1);
        hsel <= 0;
        htr <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (hro !== 1'b1);
        rdat = hrd;
    endtask
    task smp(input logic [7:0] c, input logic u, input logic o);
        code <= c;
        und <= u;
        ovr <= o;
        strb <= 1;
        repeat (2) @(posedge clk);
        strb <= 0;
        repeat (8) @(posedge clk);
    endtask
    task cur(input logic [2:0] g, input logic [2:0] c);
        repeat (4) @(posedge clk);
        chk(8'(gain), 8'(g));
        chk(8'(clamp), 8'(c));
    endtask
    task t_regs;
        ahb(0, 8'h00, 0);
        chk(8'(rdat), 8'h02);
        ahb(1, 8'h20, 32'hF);
        ahb(0, 8'h20, 0);
        chk(8'(|rdat), 8'h00);
        chk(8'(hresp), 8'h00);
        ahb(0, 8'h00, 0);
        chk(8'(rdat), 8'h02);
    endtask
    task t_src;
        for (int i = 0; i < 4; i++)
        begin
            ahb(1, 8'h00, 32'(i * 4 + 2));
            repeat (3) @(posedge clk);
            chk(8'(src), (i == 3) ? 8'h2 : 8'(i));
        end
    endtask
    task t_fmt;
        logic [7:0] b;
        for (int f = 0; f < 4; f += (f == 0) ? 2 : 1)
        begin
            ahb(1, 8'h00, 32'(f));
            repeat (3) @(posedge clk);
            for (int k = 0; k < 3; k++)
            begin
                b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'h5A;
                smp(8'h5A, k == 0, k == 1);
                chk(last, (f == 0) ? b ^ 8'h80 : b);
                chk(8'(oe_n), 8'h0);
            end
        end
        ahb(1, 8'h00, 32'h1);
        repeat (3) @(posedge clk);
        n0 = cnt;
        smp(8'h11, 0, 0);
        chk(8'(oe_n), 8'h1);
        chk(8'(cnt - n0), 8'h0);
        ahb(1, 8'h00, 32'h2);
    endtask
    task t_mode1;
        ga <= 1;
        gb <= 1;
        smp(8'h00, 1, 0);
        cur(`VAC_CUR_SNK_2U5, `VAC_CUR_SRC_130U);
        smp(8'hFF, 0, 1);
        cur(`VAC_CUR_SRC_130U, `VAC_CUR_SNK_2U5);
    endtask
    task t_mode2;
        gb <= 0;
        repeat (8) @(posedge clk);
        ga <= 0;
        repeat (8) @(posedge clk);
        gb <= 1;
        smp(8'h0A, 0, 0);
        ahb(0, 8'h04, 0);
        chk(8'(rdat[11:10]), 8'h2);
        cur(`VAC_CUR_ZERO, `VAC_CUR_SRC_50U);
        smp(8'hC8, 0, 0);
        cur(`VAC_CUR_ZERO, `VAC_CUR_SNK_50U);
        ga <= 1;
        gb <= 0;
        smp(8'h00, 1, 0);
        cur(`VAC_CUR_SRC_2U5, `VAC_CUR_ZERO);
        smp(8'hFF, 0, 1);
        cur(`VAC_CUR_SNK_2U5, `VAC_CUR_ZERO);
    endtask
    task t_fifo;
        // sink stalls so the buffer must refuse, then drains empty
        stall <= 1;
        n0 = cnt;
        for (int i = 0; i < 20; i++)
            smp(8'(i), 0, 0);
        ahb(0, 8'h04, 0);
        chk(8'(rdat[18]), 8'h1);
        stall <= 0;
        repeat (60) @(posedge clk);
        ahb(0, 8'h04, 0);
        chk(8'(rdat[19]), 8'h1);
        chk(8'((cnt - n0) >= 16), 8'h1);
        chk(last, 8'h10);
    endtask
    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs;
        t_src;
        t_fmt;
        t_mode1;
        t_mode2;
        t_fifo;
        results;
    end
    initial
    begin
        repeat (6000) @(posedge clk);
        miscompares++;
        results;
    end
endmodule // test_video_adc_clamp_gain_output_control
`default_nettype wire
